// file: logic/cfs_flag_alu.sv
// Combinational ALU that yields a result and the zero, digit-carry and carry flags.
`timescale 1ns/1ns
module cfs_flag_alu (
    input wire cfs_pkg::cfs_alu_op_t op,
    input wire logic [7:0] op_a,
    input wire logic [7:0] op_b,
    output logic [7:0] result,
    output cfs_pkg::cfs_alu_flags_t flags,
    output cfs_pkg::cfs_alu_flags_t update
);

    logic [7:0] b_eff;
    logic carry_in;
    logic [8:0] full_sum;
    logic [4:0] nibble_sum;

    // Subtraction adds the two's complement, so carry out means no borrow.
    always_comb begin
        b_eff = (op == cfs_pkg::CFS_OP_SUB) ? ~op_b : op_b;
        carry_in = (op == cfs_pkg::CFS_OP_SUB);
        full_sum = {1'b0, op_a} + {1'b0, b_eff} + {8'h00, carry_in};
        nibble_sum = {1'b0, op_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, carry_in};
    end

    // Result selection and flag update enables per operation.
    always_comb begin
        result = full_sum[7:0];
        update = '{zero: 1'b1, digit_carry: 1'b0, carry: 1'b0};
        case (op)
            cfs_pkg::CFS_OP_ADD, cfs_pkg::CFS_OP_SUB: begin
                update = '{zero: 1'b1, digit_carry: 1'b1, carry: 1'b1};
            end
            cfs_pkg::CFS_OP_AND: begin
                result = op_a & op_b;
            end
            cfs_pkg::CFS_OP_OR: begin
                result = op_a | op_b;
            end
            cfs_pkg::CFS_OP_XOR: begin
                result = op_a ^ op_b;
            end
            cfs_pkg::CFS_OP_MOVE: begin
                result = op_a;
            end
            default: begin
                result = op_a;
                update = '{zero: 1'b0, digit_carry: 1'b0, carry: 1'b0};
            end
        endcase
    end

    // Flag values; carry flags are inverted borrows in subtraction.
    always_comb begin
        flags.zero = (result == 8'h00);
        flags.digit_carry = nibble_sum[4];
        flags.carry = full_sum[8];
    end

endmodule : cfs_flag_alu

// file: logic/cfs_pkg.sv
// Package with the address map, bit layout, reset values and types of the core flags register.
package cfs_pkg;

    // Data-space addresses at which the flags register answers, one per bank.
    localparam logic [7:0] CFS_ADDR_BANK0 = 8'h03;
    localparam logic [7:0] CFS_ADDR_BANK1 = 8'h83;

    // Field positions inside the flags register.
    localparam int CFS_BIT_RESERVED_INDIRECT_PAGE = 7;
    localparam int CFS_BIT_RESERVED_BANK_HIGH = 6;
    localparam int CFS_BIT_BANK_SELECT = 5;
    localparam int CFS_BIT_TIMEOUT = 4;
    localparam int CFS_BIT_POWER_DOWN = 3;
    localparam int CFS_BIT_ZERO = 2;
    localparam int CFS_BIT_DIGIT_CARRY = 1;
    localparam int CFS_BIT_CARRY = 0;

    // Value after power-up: bank zero, time-out and power-down set, ALU flags cleared.
    localparam logic [7:0] CFS_FLAGS_RESET = 8'h18;

    // Value returned for a read that does not hit the flags register.
    localparam logic [7:0] CFS_READ_MISS = 8'h00;

    // Operations that the flag logic understands.
    typedef enum logic [2:0] {
        CFS_OP_ADD,
        CFS_OP_SUB,
        CFS_OP_AND,
        CFS_OP_OR,
        CFS_OP_XOR,
        CFS_OP_MOVE
    } cfs_alu_op_t;

    // The three arithmetic flags, used both as values and as update enables.
    typedef struct packed {
        logic zero;
        logic digit_carry;
        logic carry;
    } cfs_alu_flags_t;

    // True when a full data-space address selects the flags register in either bank.
    function automatic logic cfs_addr_hit(input logic [7:0] addr);
        cfs_addr_hit = (addr == CFS_ADDR_BANK0) || (addr == CFS_ADDR_BANK1);
    endfunction : cfs_addr_hit

endpackage : cfs_pkg

// file: logic/cfs_status.sv
// Core flags register with write protection, reset-cause flags and bank selection.
`timescale 1ns/1ns
module cfs_status (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] bus_addr,
    input wire logic bus_wr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_clr,
    input wire logic bus_rd,
    output logic [7:0] bus_rdata,
    output logic bus_rvalid,
    input wire logic alu_valid,
    input wire cfs_pkg::cfs_alu_op_t alu_op,
    input wire logic [7:0] alu_a,
    input wire logic [7:0] alu_b,
    output logic [7:0] alu_result,
    input wire logic watchdog_clear_instr,
    input wire logic sleep_instr,
    input wire logic watchdog_timeout,
    input wire logic [6:0] direct_addr,
    output logic [7:0] direct_phys_addr,
    output logic [7:0] flags_out,
    output logic bank_select
);

    // Whole state of the block.
    typedef struct packed {
        logic [7:0] flags;
        logic [7:0] rdata;
        logic rvalid;
    } cfs_state_t;

    cfs_state_t state;
    cfs_state_t next_state;
    cfs_pkg::cfs_alu_flags_t alu_flags;
    cfs_pkg::cfs_alu_flags_t alu_update;
    logic hit_wr;
    logic hit_clr;
    logic hit_rd;
    logic alu_owns_flags;

    // Shared ALU that produces the arithmetic flags.
    cfs_flag_alu u_alu (
        .op(alu_op),
        .op_a(alu_a),
        .op_b(alu_b),
        .result(alu_result),
        .flags(alu_flags),
        .update(alu_update)
    );

    // Address decode for both bank mirrors.
    assign hit_wr = bus_wr && cfs_pkg::cfs_addr_hit(bus_addr);
    assign hit_clr = bus_clr && cfs_pkg::cfs_addr_hit(bus_addr);
    assign hit_rd = bus_rd && cfs_pkg::cfs_addr_hit(bus_addr);

    // Any flag-setting operation in the same cycle blocks the write of all three ALU flags.
    assign alu_owns_flags = alu_valid &&
        (alu_update.zero || alu_update.digit_carry || alu_update.carry);

    // Next-state logic for writes, clears, ALU updates and reset-cause events.
    always_comb begin
        next_state = state;
        next_state.rvalid = 1'b0;
        if (hit_wr) begin
            // Upper three bits take the written value; time-out and power-down never do.
            next_state.flags[7:5] = bus_wdata[7:5];
            if (!alu_owns_flags) begin
                next_state.flags[cfs_pkg::CFS_BIT_ZERO] = bus_wdata[cfs_pkg::CFS_BIT_ZERO];
            end
            if (!alu_owns_flags) begin
                next_state.flags[cfs_pkg::CFS_BIT_DIGIT_CARRY] =
                    bus_wdata[cfs_pkg::CFS_BIT_DIGIT_CARRY];
            end
            if (!alu_owns_flags) begin
                next_state.flags[cfs_pkg::CFS_BIT_CARRY] = bus_wdata[cfs_pkg::CFS_BIT_CARRY];
            end
        end
        // ALU results override any written value of the arithmetic flags.
        if (alu_valid) begin
            if (alu_update.zero) begin
                next_state.flags[cfs_pkg::CFS_BIT_ZERO] = alu_flags.zero;
            end
            if (alu_update.digit_carry) begin
                next_state.flags[cfs_pkg::CFS_BIT_DIGIT_CARRY] =
                    alu_flags.digit_carry;
            end
            if (alu_update.carry) begin
                next_state.flags[cfs_pkg::CFS_BIT_CARRY] = alu_flags.carry;
            end
        end
        // A register clear leaves a zero result, so the zero flag rises.
        if (hit_clr) begin
            next_state.flags[7:5] = 3'h0;
            next_state.flags[cfs_pkg::CFS_BIT_ZERO] = 1'b1;
        end
        // Clearing events first, so a coincident setting event wins.
        if (watchdog_timeout) begin
            next_state.flags[cfs_pkg::CFS_BIT_TIMEOUT] = 1'b0;
        end
        if (sleep_instr) begin
            next_state.flags[cfs_pkg::CFS_BIT_POWER_DOWN] = 1'b0;
        end
        if (watchdog_clear_instr || sleep_instr) begin
            next_state.flags[cfs_pkg::CFS_BIT_TIMEOUT] = 1'b1;
        end
        if (watchdog_clear_instr) begin
            next_state.flags[cfs_pkg::CFS_BIT_POWER_DOWN] = 1'b1;
        end
        // Reads capture the value held before this cycle's update.
        if (bus_rd) begin
            next_state.rvalid = 1'b1;
            next_state.rdata = hit_rd ? state.flags : cfs_pkg::CFS_READ_MISS;
        end
    end

    // State register; power-up reset loads the documented flag values.
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= '{flags: cfs_pkg::CFS_FLAGS_RESET, rdata: 8'h00, rvalid: 1'b0};
        end else begin
            state <= next_state;
        end
    end

    // Outputs and the direct-address bank mapping.
    assign bus_rdata = state.rdata;
    assign bus_rvalid = state.rvalid;
    assign flags_out = state.flags;
    assign bank_select = state.flags[cfs_pkg::CFS_BIT_BANK_SELECT];
    assign direct_phys_addr = {bank_select, direct_addr};

    // Helper values for the checks below.
    logic quiet_events;
    logic [4:0] add_nibble;
    logic [8:0] add_sum;
    assign quiet_events = !watchdog_clear_instr && !sleep_instr && !watchdog_timeout;
    assign add_nibble = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]};
    assign add_sum = {1'b0, alu_a} + {1'b0, alu_b};

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_sleep_alone;
        sleep_instr && !watchdog_clear_instr && !watchdog_timeout;
    endsequence

    sequence s_sleep_result;
        !flags_out[cfs_pkg::CFS_BIT_POWER_DOWN] && flags_out[cfs_pkg::CFS_BIT_TIMEOUT];
    endsequence

    a_reset_flags: assert property (disable iff (1'b0) rst |=> flags_out[5:3] == 3'h3)
        else $error("Flags wrong after reset.");

    a_ro_cause_bits: assert property ((hit_wr || hit_clr) && quiet_events |=>
        flags_out[4:3] == $past(flags_out[4:3]))
        else $error("Write changed time-out or power-down.");

    a_write_upper: assert property (hit_wr && !hit_clr |=>
        flags_out[7:5] == $past(bus_wdata[7:5]))
        else $error("Upper bits not written.");

    a_alu_override: assert property (hit_wr && alu_valid && alu_update.zero &&
        !hit_clr |=>
        flags_out[cfs_pkg::CFS_BIT_ZERO] == $past(alu_flags.zero))
        else $error("Write overrode ALU zero flag.");

    a_clear_result: assert property (hit_clr |=>
        flags_out[7:5] == 3'h0 && flags_out[cfs_pkg::CFS_BIT_ZERO])
        else $error("Register clear result wrong.");

    a_sub_no_borrow: assert property (alu_valid && alu_op == cfs_pkg::CFS_OP_SUB &&
        alu_a >= alu_b |=> flags_out[cfs_pkg::CFS_BIT_CARRY])
        else $error("Subtract without borrow cleared carry.");

    a_add_digit: assert property (alu_valid && alu_op == cfs_pkg::CFS_OP_ADD |=>
        flags_out[cfs_pkg::CFS_BIT_DIGIT_CARRY] == $past(add_nibble[4]))
        else $error("Digit carry wrong on add.");

    a_zero_logic: assert property (alu_valid && alu_op == cfs_pkg::CFS_OP_AND &&
        !hit_clr |=>
        flags_out[cfs_pkg::CFS_BIT_ZERO] == ($past(alu_a & alu_b) == 8'h00))
        else $error("Zero flag wrong on logic operation.");

    a_sleep_flags: assert property (s_sleep_alone |=> s_sleep_result)
        else $error("Sleep did not set time-out and clear power-down.");

    a_timeout_clear: assert property (watchdog_timeout && !watchdog_clear_instr &&
        !sleep_instr |=> !flags_out[cfs_pkg::CFS_BIT_TIMEOUT])
        else $error("Watchdog expiry did not clear time-out.");

    a_read_mirror: assert property (hit_rd |=>
        bus_rvalid && bus_rdata == $past(flags_out))
        else $error("Read of flags register wrong.");

    a_bank_map: assert property (direct_phys_addr[7] == bank_select &&
        direct_phys_addr[6:0] == direct_addr)
        else $error("Direct address not mapped by bank bit.");

    a_logic_keeps_carry: assert property (hit_wr && alu_valid &&
        alu_op != cfs_pkg::CFS_OP_ADD && alu_op != cfs_pkg::CFS_OP_SUB |=>
        flags_out[1:0] == $past(flags_out[1:0]))
        else $error("Write reached carry flags during a flag-setting operation.");

    a_add_carry: assert property (alu_valid && alu_op == cfs_pkg::CFS_OP_ADD |=>
        flags_out[cfs_pkg::CFS_BIT_CARRY] == $past(add_sum[8]))
        else $error("Carry wrong on add.");

    a_sub_borrow: assert property (alu_valid && alu_op == cfs_pkg::CFS_OP_SUB &&
        alu_a < alu_b |=> !flags_out[cfs_pkg::CFS_BIT_CARRY])
        else $error("Subtract with borrow set carry.");

    a_sub_digit: assert property (alu_valid && alu_op == cfs_pkg::CFS_OP_SUB &&
        1'b1 |=> flags_out[cfs_pkg::CFS_BIT_DIGIT_CARRY] == $past(alu_a[3:0] >= alu_b[3:0]))
        else $error("Digit borrow wrong on subtract.");

    a_wdc_flags: assert property (watchdog_clear_instr |=>
        flags_out[4:3] == 2'h3)
        else $error("Watchdog clear did not set time-out and power-down.");

    a_read_miss: assert property (bus_rd && !hit_rd |=>
        bus_rvalid && bus_rdata == cfs_pkg::CFS_READ_MISS)
        else $error("Read outside the flags register returned data.");

endmodule : cfs_status

// file: testbench/cfs_status_bench.sv
// Self-checking bench that compares the core flags register with a behavioural model.
`timescale 1ns/1ns
module cfs_status_bench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] bus_addr = 8'h00;
    logic bus_wr = 1'b0;
    logic [7:0] bus_wdata = 8'h00;
    logic bus_clr = 1'b0;
    logic bus_rd = 1'b0;
    logic alu_valid = 1'b0;
    cfs_pkg::cfs_alu_op_t alu_op = cfs_pkg::CFS_OP_ADD;
    logic [7:0] alu_a = 8'h00;
    logic [7:0] alu_b = 8'h00;
    logic wdog_clr = 1'b0;
    logic sleep_instr = 1'b0;
    logic wdog_tmo = 1'b0;
    logic [6:0] direct_addr = 7'h00;
    logic [7:0] bus_rdata, alu_result, direct_phys_addr, flags_out;
    logic bus_rvalid, bank_select;
    logic [7:0] mf = 8'h18;
    logic [7:0] m_rdata = 8'h00;
    logic m_rvalid = 1'b0;
    int mismatches = 0;
    int samples_checked = 0;

    cfs_status i_dut (.clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_wr(bus_wr),
        .bus_wdata(bus_wdata), .bus_clr(bus_clr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .bus_rvalid(bus_rvalid), .alu_valid(alu_valid), .alu_op(alu_op), .alu_a(alu_a),
        .alu_b(alu_b), .alu_result(alu_result), .watchdog_clear_instr(wdog_clr),
        .sleep_instr(sleep_instr), .watchdog_timeout(wdog_tmo), .direct_addr(direct_addr),
        .direct_phys_addr(direct_phys_addr), .flags_out(flags_out), .bank_select(bank_select));

    // Free-running 25 MHz clock.
    always #20 clk = ~clk;

    // Compares one value and counts the outcome.
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish

    // Reference ALU in integers: returns digit carry, carry and the 8-bit result.
    function automatic logic [9:0] alu_ref(input cfs_pkg::cfs_alu_op_t op, input int a,
        input int b);
        int r, cy, dcy;
        cy = 0;
        dcy = 0;
        case (op)
            cfs_pkg::CFS_OP_ADD: begin
                r = a + b;
                dcy = ((a % 16) + (b % 16)) > 15;
            end
            cfs_pkg::CFS_OP_SUB: begin
                r = a + (255 - b) + 1;
                dcy = ((a % 16) + (15 - b % 16) + 1) > 15;
            end
            cfs_pkg::CFS_OP_AND: r = a & b;
            cfs_pkg::CFS_OP_OR: r = a | b;
            cfs_pkg::CFS_OP_XOR: r = a ^ b;
            default: r = a;
        endcase
        cy = r > 255;
        alu_ref = {dcy[0], cy[0], r[7:0]};
    endfunction : alu_ref

    // Model of one rising edge in the documented priority order.
    task automatic model_edge(input logic [9:0] alu_expect);
        logic hit;
        hit = (bus_addr == 8'h03) || (bus_addr == 8'h83);
        m_rvalid = bus_rd;
        if (bus_rd) m_rdata = hit ? mf : 8'h00;
        // A flag-setting operation blocks the write of all three arithmetic flags.
        if (bus_wr && hit && alu_valid) mf = (mf & 8'h1F) | (bus_wdata & 8'hE0);
        else if (bus_wr && hit) mf = (mf & 8'h18) | (bus_wdata & 8'hE7);
        if (alu_valid) begin
            mf[2] = (alu_expect[7:0] == 8'h00);
            if (alu_op == cfs_pkg::CFS_OP_ADD || alu_op == cfs_pkg::CFS_OP_SUB) begin
                mf[1] = alu_expect[9];
                mf[0] = alu_expect[8];
            end
        end
        if (bus_clr && hit) mf = (mf & 8'h1B) | 8'h04;
        if (wdog_tmo) mf[4] = 1'b0;
        if (sleep_instr) mf[4:3] = 2'b10;
        if (wdog_clr) mf[4:3] = 2'b11;
    endtask : model_edge

    // Runs one cycle with the inputs already driven and checks every result.
    task automatic step;
        logic [9:0] alu_expect;
        #1;
        alu_expect = alu_ref(alu_op, int'(alu_a), int'(alu_b));
        chk("alu_result", alu_expect[7:0], alu_result);
        chk("direct_phys_addr", {mf[5], direct_addr}, direct_phys_addr);
        @(posedge clk);
        model_edge(alu_expect);
        @(negedge clk);
        chk("flags_out", mf, flags_out);
        chk("cause_flags", {6'h00, mf[4:3]}, {6'h00, flags_out[4:3]});
        chk("digit_carry", {7'h00, mf[1]}, {7'h00, flags_out[1]});
        chk("carry", {7'h00, mf[0]}, {7'h00, flags_out[0]});
        chk("bank_select", {7'h00, mf[5]}, {7'h00, bank_select});
        chk("bus_rvalid", {7'h00, m_rvalid}, {7'h00, bus_rvalid});
        chk("bus_rdata", m_rdata, bus_rdata);
    endtask : step

    // Watchdog that cuts a hung run short.
    initial begin
        #(40 * 5000);
        mismatches++;
        tally_and_finish();
    end

    // Reset, a directed subtraction, then random traffic on every input.
    initial begin
        void'($urandom(32'h39e0));
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        chk("flags_reset", 8'h18, flags_out);
        alu_valid = 1'b1;
        alu_op = cfs_pkg::CFS_OP_SUB;
        alu_a = 8'h05;
        alu_b = 8'h05;
        step();
        // A plain move into the bank-one mirror sets the bank bit, then a read and a clear.
        alu_valid = 1'b0;
        bus_wr = 1'b1;
        bus_addr = 8'h83;
        bus_wdata = 8'h20;
        step();
        bus_wr = 1'b0;
        bus_rd = 1'b1;
        bus_addr = 8'h03;
        step();
        bus_rd = 1'b0;
        bus_clr = 1'b1;
        step();
        bus_clr = 1'b0;
        for (int i = 0; i < 4000; i++) begin
            case ($urandom % 4)
                0: bus_addr = 8'h03;
                1: bus_addr = 8'h83;
                default: bus_addr = 8'($urandom);
            endcase
            bus_wr = ($urandom % 3) == 0;
            bus_wdata = 8'($urandom) & 8'h3F;
            bus_clr = ($urandom % 6) == 0;
            bus_rd = ($urandom % 2) == 0;
            alu_valid = ($urandom % 2) == 0;
            alu_op = cfs_pkg::cfs_alu_op_t'(3'($urandom % 6));
            alu_a = 8'($urandom);
            alu_b = (($urandom % 4) == 0) ? alu_a : 8'($urandom);
            wdog_clr = ($urandom % 8) == 0;
            sleep_instr = ($urandom % 8) == 0;
            wdog_tmo = ($urandom % 6) == 0;
            direct_addr = 7'($urandom);
            step();
        end
        // Mid-run reset with the bank bit set; flags, bank bit and read-valid return to their power-up values.
        bus_addr = 8'h03;
        bus_wr = 1'b1;
        bus_wdata = 8'h20;
        bus_clr = 1'b0;
        bus_rd = 1'b0;
        alu_valid = 1'b0;
        wdog_clr = 1'b0;
        sleep_instr = 1'b0;
        wdog_tmo = 1'b0;
        step();
        bus_wr = 1'b0;
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        mf = 8'h18;
        m_rdata = 8'h00;
        m_rvalid = 1'b0;
        chk("flags_reset", 8'h18, flags_out);
        chk("bank_select", 8'h00, {7'h00, bank_select});
        chk("bus_rvalid", 8'h00, {7'h00, bus_rvalid});
        bus_rd = 1'b1;
        bus_addr = 8'h83;
        step();
        tally_and_finish();
    end
endmodule : cfs_status_bench
